// ---- core/mbx_pkg.sv ----
// Constants, operation codes and state types of the branch, table-read,
// miscellaneous and add execution unit.
// Assumes one system clock; an instruction cycle spans four of its edges.
package mbx_pkg;

  localparam int DATA_W  = 8;
  localparam int ROM_W   = 14;
  localparam int ROM_AW  = 11;
  localparam int PAGE_W  = 3;
  localparam int CNT_W   = 4;
  localparam int NCYC_W  = 2;

  // System clocks in one instruction cycle.
  localparam logic [CNT_W-1:0]  CLKS_PER_CYC = 4'h4;
  // Clocks trimmed from the busy count: the issue clock and the return clock.
  localparam logic [CNT_W-1:0]  BUSY_TRIM    = 4'h2;
  // Busy clock on which the program word is captured by a table read.
  localparam logic [CNT_W-1:0]  TBL_CAPTURE  = 4'h2;

  localparam logic [NCYC_W-1:0] CYC_ONE      = 2'h1;
  localparam logic [NCYC_W-1:0] CYC_TWO      = 2'h2;
  localparam logic [NCYC_W-1:0] CYC_NONE     = 2'h0;

  localparam logic [PAGE_W-1:0] LAST_PAGE    = 3'h7;
  localparam logic [DATA_W-1:0] BYTE_ZERO    = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONES    = 8'hff;
  localparam logic [DATA_W-1:0] BYTE_ONE     = 8'h01;
  localparam int                NIB_W        = 4;
  localparam int                MSB          = 7;

  typedef enum logic [4:0] {
    OP_NOP, OP_JUMP, OP_CALL, OP_RETURN, OP_RETURN_IMM, OP_INT_RETURN,
    OP_SKIP_ZERO, OP_SKIP_ZERO_COPY, OP_SKIP_BIT_CLR, OP_SKIP_BIT_SET,
    OP_INC_SKIP, OP_DEC_SKIP, OP_INC_SKIP_W, OP_DEC_SKIP_W,
    OP_TABLE_READ, OP_TABLE_READ_LAST, OP_CLEAR, OP_SET,
    OP_WDOG_CLEAR, OP_WDOG_PRE1, OP_WDOG_PRE2, OP_SWAP, OP_SWAP_W,
    OP_HALT, OP_ADD_CARRY, OP_ADD_CARRY_MEM, OP_ADD, OP_ADD_IMM, OP_ADD_MEM
  } mbx_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_HALT} mbx_state_t;

endpackage

// ---- core/mbx_exec.sv ----
// Execution unit for branch, skip, table read, miscellaneous and add operations.
// Assumes a fetch/decode stage on MCLK presenting one operation with ISSUE
// while READY is high, a data memory read port and a program memory read port.
`timescale 1ns/1ps
`default_nettype none

module mbx_exec (
  // Clock and reset.
  input  wire logic                          MCLK,
  input  wire logic                          RESETN,
  // Operation issue.
  input  wire logic                          ISSUE,
  input  wire mbx_pkg::mbx_op_t              OPCODE,
  input  wire logic [mbx_pkg::DATA_W-1:0]    IMM,
  input  wire logic [2:0]                    BIT_SEL,
  input  wire logic                          DEST_PCL,
  input  wire logic                          TBL_HIGH_OPT,
  // Data memory and pointers.
  input  wire logic [mbx_pkg::DATA_W-1:0]    MEM_RDATA,
  input  wire logic [mbx_pkg::DATA_W-1:0]    TABLE_POINTER_LOW,
  input  wire logic [mbx_pkg::PAGE_W-1:0]    TABLE_POINTER_HIGH,
  input  wire logic [mbx_pkg::PAGE_W-1:0]    PC_PAGE,
  input  wire logic [mbx_pkg::ROM_W-1:0]     ROM_DATA,
  // Watchdog and wake events.
  input  wire logic                          WDT_TIMEOUT,
  input  wire logic                          WAKE,
  // Sequencing outputs.
  output logic                               READY,
  output logic                               SKIP,
  output logic                               PC_LOAD,
  output logic                               STACK_PUSH,
  output logic                               STACK_POP,
  output logic                               INT_RETURN,
  output logic                               HALTED,
  output logic                               WATCHDOG_CLEAR,
  // Memory outputs.
  output logic                               ROM_RD,
  output logic [mbx_pkg::ROM_AW-1:0]         ROM_ADDR,
  output logic                               MEM_WE,
  output logic [mbx_pkg::DATA_W-1:0]         MEM_WDATA,
  output logic [mbx_pkg::ROM_W-mbx_pkg::DATA_W-1:0] TABLE_HIGH_LATCH,
  // Working register and flags.
  output logic [mbx_pkg::DATA_W-1:0]         WORKING_REGISTER,
  output logic                               CARRY_FLAG,
  output logic                               HALF_CARRY_FLAG,
  output logic                               ZERO_FLAG,
  output logic                               OVERFLOW_FLAG,
  output logic                               TIMEOUT_FLAG,
  output logic                               POWERDOWN_FLAG
);

  localparam int HI_W = mbx_pkg::ROM_W - mbx_pkg::DATA_W;

  // Eight-bit add returning overflow, half carry, carry and sum.
  function automatic logic [mbx_pkg::DATA_W+2:0] add8(
    input logic [mbx_pkg::DATA_W-1:0] a,
    input logic [mbx_pkg::DATA_W-1:0] b,
    input logic                       cin
  );
    logic [mbx_pkg::NIB_W:0]   lo;
    logic [mbx_pkg::DATA_W-1:0] s7;
    logic [mbx_pkg::DATA_W:0]  full;
    lo   = {1'b0, a[mbx_pkg::NIB_W-1:0]} + {1'b0, b[mbx_pkg::NIB_W-1:0]} + {4'h0, cin};
    s7   = {1'b0, a[mbx_pkg::MSB-1:0]} + {1'b0, b[mbx_pkg::MSB-1:0]} + {7'h00, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    add8 = {full[mbx_pkg::DATA_W] ^ s7[mbx_pkg::MSB], lo[mbx_pkg::NIB_W],
            full[mbx_pkg::DATA_W], full[mbx_pkg::DATA_W-1:0]};
  endfunction

  mbx_pkg::mbx_state_t               state_q, state_d;
  logic [mbx_pkg::CNT_W-1:0]         cnt_q, cnt_d, last_q, last_d;
  logic                              tbl_pend_q, tbl_pend_d, halt_pend_q, halt_pend_d;
  logic                              pre1_q, pre1_d, pre2_q, pre2_d;
  logic                              ready_q, ready_d, skip_q, skip_d, pcl_q, pcl_d;
  logic                              push_q, push_d, pop_q, pop_d, iret_q, iret_d;
  logic                              halted_q, halted_d, wclr_q, wclr_d;
  logic                              rom_rd_q, rom_rd_d, mem_we_q, mem_we_d;
  logic [mbx_pkg::ROM_AW-1:0]        rom_addr_q, rom_addr_d;
  logic [mbx_pkg::DATA_W-1:0]        wdata_q, wdata_d, acc_q, acc_d;
  logic [HI_W-1:0]                   table_high_latch_q, table_high_latch_d;
  logic                              c_q, c_d, hc_q, hc_d, z_q, z_d, ov_q, ov_d;
  logic                              to_q, to_d, pd_q, pd_d;
  logic [mbx_pkg::DATA_W+2:0]        sum;
  logic [mbx_pkg::DATA_W-1:0]        inc_v, dec_v, adj_v, swap_v;
  logic [mbx_pkg::NCYC_W-1:0]        ncyc;
  logic                              skip_now, pcl_pen;

  always_comb begin
    sum      = add8(acc_q, (OPCODE == mbx_pkg::OP_ADD_IMM) ? IMM : MEM_RDATA,
                    (OPCODE == mbx_pkg::OP_ADD_CARRY || OPCODE == mbx_pkg::OP_ADD_CARRY_MEM) & c_q);
    inc_v    = MEM_RDATA + mbx_pkg::BYTE_ONE;
    dec_v    = MEM_RDATA - mbx_pkg::BYTE_ONE;
    adj_v    = (OPCODE == mbx_pkg::OP_INC_SKIP || OPCODE == mbx_pkg::OP_INC_SKIP_W) ? inc_v : dec_v;
    swap_v   = {MEM_RDATA[mbx_pkg::NIB_W-1:0], MEM_RDATA[mbx_pkg::DATA_W-1:mbx_pkg::NIB_W]};
    ncyc     = mbx_pkg::CYC_ONE;
    skip_now = 1'b0;
    pcl_pen  = 1'b0;
    state_d = state_q;  cnt_d = cnt_q;  last_d = last_q;
    tbl_pend_d = tbl_pend_q;  halt_pend_d = halt_pend_q;
    pre1_d = pre1_q;  pre2_d = pre2_q;  ready_d = ready_q;  halted_d = halted_q;
    skip_d = 1'b0;  pcl_d = 1'b0;  push_d = 1'b0;  pop_d = 1'b0;  iret_d = 1'b0;
    wclr_d = 1'b0;  rom_rd_d = 1'b0;  mem_we_d = 1'b0;
    rom_addr_d = rom_addr_q;  wdata_d = wdata_q;  acc_d = acc_q;  table_high_latch_d = table_high_latch_q;
    c_d = c_q;  hc_d = hc_q;  z_d = z_q;  ov_d = ov_q;  to_d = to_q;  pd_d = pd_q;
    unique case (state_q)
      mbx_pkg::ST_IDLE: begin
        if (ISSUE) begin
          unique case (OPCODE)
            mbx_pkg::OP_NOP: begin
            end
            mbx_pkg::OP_JUMP, mbx_pkg::OP_CALL, mbx_pkg::OP_RETURN,
            mbx_pkg::OP_RETURN_IMM, mbx_pkg::OP_INT_RETURN: begin
              ncyc   = mbx_pkg::CYC_TWO;
              pcl_d  = 1'b1;
              push_d = (OPCODE == mbx_pkg::OP_CALL);
              pop_d  = (OPCODE != mbx_pkg::OP_JUMP) && (OPCODE != mbx_pkg::OP_CALL);
              iret_d = (OPCODE == mbx_pkg::OP_INT_RETURN);
              if (OPCODE == mbx_pkg::OP_RETURN_IMM) begin
                acc_d = IMM;
              end
            end
            mbx_pkg::OP_SKIP_ZERO, mbx_pkg::OP_SKIP_ZERO_COPY: begin
              skip_now = (MEM_RDATA == mbx_pkg::BYTE_ZERO);
              if (OPCODE == mbx_pkg::OP_SKIP_ZERO_COPY) begin
                acc_d = MEM_RDATA;
              end
            end
            mbx_pkg::OP_SKIP_BIT_CLR: begin
              skip_now = ~MEM_RDATA[BIT_SEL];
            end
            mbx_pkg::OP_SKIP_BIT_SET: begin
              skip_now = MEM_RDATA[BIT_SEL];
            end
            mbx_pkg::OP_INC_SKIP, mbx_pkg::OP_DEC_SKIP: begin
              skip_now = (adj_v == mbx_pkg::BYTE_ZERO);
              mem_we_d = 1'b1;
              wdata_d  = adj_v;
              pcl_pen  = DEST_PCL;
            end
            mbx_pkg::OP_INC_SKIP_W, mbx_pkg::OP_DEC_SKIP_W: begin
              skip_now = (adj_v == mbx_pkg::BYTE_ZERO);
              acc_d    = adj_v;
            end
            mbx_pkg::OP_TABLE_READ, mbx_pkg::OP_TABLE_READ_LAST: begin
              ncyc       = mbx_pkg::CYC_TWO;
              pcl_pen    = DEST_PCL;
              rom_rd_d   = 1'b1;
              tbl_pend_d = 1'b1;
              if (OPCODE == mbx_pkg::OP_TABLE_READ_LAST) begin
                rom_addr_d = {mbx_pkg::LAST_PAGE, TABLE_POINTER_LOW};
              end else if (TBL_HIGH_OPT) begin
                rom_addr_d = {TABLE_POINTER_HIGH, TABLE_POINTER_LOW};
              end else begin
                rom_addr_d = {PC_PAGE, TABLE_POINTER_LOW};
              end
            end
            mbx_pkg::OP_CLEAR, mbx_pkg::OP_SET: begin
              mem_we_d = 1'b1;
              wdata_d  = (OPCODE == mbx_pkg::OP_SET) ? mbx_pkg::BYTE_ONES : mbx_pkg::BYTE_ZERO;
              pcl_pen  = DEST_PCL;
            end
            mbx_pkg::OP_WDOG_CLEAR: begin
              wclr_d = 1'b1;
              to_d   = 1'b0;
              pd_d   = 1'b0;
            end
            mbx_pkg::OP_WDOG_PRE1, mbx_pkg::OP_WDOG_PRE2: begin
              if ((OPCODE == mbx_pkg::OP_WDOG_PRE1) ? pre2_q : pre1_q) begin
                wclr_d = 1'b1;
                to_d   = 1'b0;
                pd_d   = 1'b0;
                pre1_d = 1'b0;
                pre2_d = 1'b0;
              end else begin
                pre1_d = pre1_q | (OPCODE == mbx_pkg::OP_WDOG_PRE1);
                pre2_d = pre2_q | (OPCODE == mbx_pkg::OP_WDOG_PRE2);
              end
            end
            mbx_pkg::OP_SWAP: begin
              mem_we_d = 1'b1;
              wdata_d  = swap_v;
              pcl_pen  = DEST_PCL;
            end
            mbx_pkg::OP_SWAP_W: begin
              acc_d = swap_v;
            end
            mbx_pkg::OP_HALT: begin
              halt_pend_d = 1'b1;
              wclr_d      = 1'b1;
              to_d        = 1'b0;
              pd_d        = 1'b1;
            end
            mbx_pkg::OP_ADD_CARRY, mbx_pkg::OP_ADD, mbx_pkg::OP_ADD_IMM: begin
              acc_d = sum[mbx_pkg::DATA_W-1:0];
              {ov_d, hc_d, c_d} = sum[mbx_pkg::DATA_W+2:mbx_pkg::DATA_W];
              z_d   = (sum[mbx_pkg::DATA_W-1:0] == mbx_pkg::BYTE_ZERO);
            end
            mbx_pkg::OP_ADD_CARRY_MEM, mbx_pkg::OP_ADD_MEM: begin
              mem_we_d = 1'b1;
              wdata_d  = sum[mbx_pkg::DATA_W-1:0];
              {ov_d, hc_d, c_d} = sum[mbx_pkg::DATA_W+2:mbx_pkg::DATA_W];
              z_d      = (sum[mbx_pkg::DATA_W-1:0] == mbx_pkg::BYTE_ZERO);
              pcl_pen  = DEST_PCL;
            end
            default: begin
            end
          endcase
          skip_d  = skip_now;
          ncyc    = ncyc + {1'b0, pcl_pen} + {1'b0, skip_now};
          last_d  = ({2'h0, ncyc} * mbx_pkg::CLKS_PER_CYC) - mbx_pkg::BUSY_TRIM;
          cnt_d   = '0;
          ready_d = 1'b0;
          state_d = mbx_pkg::ST_BUSY;
        end
      end
      mbx_pkg::ST_BUSY: begin
        cnt_d = cnt_q + 1'b1;
        if (tbl_pend_q && cnt_q == mbx_pkg::TBL_CAPTURE) begin
          mem_we_d   = 1'b1;
          wdata_d    = ROM_DATA[mbx_pkg::DATA_W-1:0];
          table_high_latch_d     = ROM_DATA[mbx_pkg::ROM_W-1:mbx_pkg::DATA_W];
          tbl_pend_d = 1'b0;
        end
        if (cnt_q == last_q) begin
          halt_pend_d = 1'b0;
          if (halt_pend_q) begin
            halted_d = 1'b1;
            state_d  = mbx_pkg::ST_HALT;
          end else begin
            ready_d = 1'b1;
            state_d = mbx_pkg::ST_IDLE;
          end
        end
      end
      mbx_pkg::ST_HALT: begin
        if (WAKE) begin
          halted_d = 1'b0;
          ready_d  = 1'b1;
          state_d  = mbx_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = mbx_pkg::ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
    if (WDT_TIMEOUT) begin
      to_d = 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= mbx_pkg::ST_IDLE;  cnt_q <= '0;  last_q <= '0;
      tbl_pend_q <= 1'b0;  halt_pend_q <= 1'b0;  pre1_q <= 1'b0;  pre2_q <= 1'b0;
      ready_q <= 1'b1;  skip_q <= 1'b0;  pcl_q <= 1'b0;  push_q <= 1'b0;
      pop_q <= 1'b0;  iret_q <= 1'b0;  halted_q <= 1'b0;  wclr_q <= 1'b0;
      rom_rd_q <= 1'b0;  mem_we_q <= 1'b0;  rom_addr_q <= '0;  wdata_q <= '0;
      acc_q <= '0;  table_high_latch_q <= '0;  c_q <= 1'b0;  hc_q <= 1'b0;  z_q <= 1'b0;
      ov_q <= 1'b0;  to_q <= 1'b0;  pd_q <= 1'b0;
    end else begin
      state_q <= state_d;  cnt_q <= cnt_d;  last_q <= last_d;
      tbl_pend_q <= tbl_pend_d;  halt_pend_q <= halt_pend_d;  pre1_q <= pre1_d;
      pre2_q <= pre2_d;  ready_q <= ready_d;  skip_q <= skip_d;  pcl_q <= pcl_d;
      push_q <= push_d;  pop_q <= pop_d;  iret_q <= iret_d;  halted_q <= halted_d;
      wclr_q <= wclr_d;  rom_rd_q <= rom_rd_d;  mem_we_q <= mem_we_d;
      rom_addr_q <= rom_addr_d;  wdata_q <= wdata_d;  acc_q <= acc_d;
      table_high_latch_q <= table_high_latch_d;  c_q <= c_d;  hc_q <= hc_d;  z_q <= z_d;  ov_q <= ov_d;
      to_q <= to_d;  pd_q <= pd_d;
    end
  end

  assign READY            = ready_q;
  assign SKIP             = skip_q;
  assign PC_LOAD          = pcl_q;
  assign STACK_PUSH       = push_q;
  assign STACK_POP        = pop_q;
  assign INT_RETURN       = iret_q;
  assign HALTED           = halted_q;
  assign WATCHDOG_CLEAR   = wclr_q;
  assign ROM_RD           = rom_rd_q;
  assign ROM_ADDR         = rom_addr_q;
  assign MEM_WE           = mem_we_q;
  assign MEM_WDATA        = wdata_q;
  assign TABLE_HIGH_LATCH = table_high_latch_q;
  assign WORKING_REGISTER = acc_q;
  assign CARRY_FLAG       = c_q;
  assign HALF_CARRY_FLAG  = hc_q;
  assign ZERO_FLAG        = z_q;
  assign OVERFLOW_FLAG    = ov_q;
  assign TIMEOUT_FLAG     = to_q;
  assign POWERDOWN_FLAG   = pd_q;

endmodule

`default_nettype wire

// ---- verif/mbx_exec_monitor.sv ----
// Concurrent checks on the ports of the execution unit.
// Assumes the unit runs on MCLK with RESETN active low and is bound below.
`timescale 1ns/1ps
`default_nettype none

module mbx_exec_monitor (
  // Clock and reset.
  input wire logic                        MCLK,
  input wire logic                        RESETN,
  // Issue side.
  input wire logic                        ISSUE,
  input wire mbx_pkg::mbx_op_t            OPCODE,
  input wire logic [mbx_pkg::DATA_W-1:0]  IMM,
  input wire logic [2:0]                  BIT_SEL,
  input wire logic                        DEST_PCL,
  input wire logic [mbx_pkg::DATA_W-1:0]  MEM_RDATA,
  input wire logic [mbx_pkg::DATA_W-1:0]  TABLE_POINTER_LOW,
  input wire logic [mbx_pkg::ROM_W-1:0]   ROM_DATA,
  input wire logic                        WDT_TIMEOUT,
  // Results.
  input wire logic                        READY,
  input wire logic                        SKIP,
  input wire logic                        PC_LOAD,
  input wire logic                        HALTED,
  input wire logic                        WATCHDOG_CLEAR,
  input wire logic [mbx_pkg::ROM_AW-1:0]  ROM_ADDR,
  input wire logic                        MEM_WE,
  input wire logic [mbx_pkg::DATA_W-1:0]  MEM_WDATA,
  input wire logic [mbx_pkg::DATA_W-1:0]  WORKING_REGISTER,
  input wire logic                        CARRY_FLAG,
  input wire logic                        TIMEOUT_FLAG,
  input wire logic                        POWERDOWN_FLAG
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  property p_jump;
    ISSUE && READY && OPCODE == mbx_pkg::OP_JUMP |=> PC_LOAD && !READY ##1 (!READY) [*6] ##1 READY;
  endproperty
  a_jump: assert property (p_jump) else $error("jump timing wrong");
  property p_skip_zero;
    ISSUE && READY && OPCODE == mbx_pkg::OP_SKIP_ZERO |=> SKIP == ($past(MEM_RDATA) == 8'h00);
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("zero skip wrong");
  property p_bit_set;
    ISSUE && READY && OPCODE == mbx_pkg::OP_SKIP_BIT_SET |=> SKIP == $past(MEM_RDATA[BIT_SEL]);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit skip wrong");
  property p_skip_time;
    SKIP && !$past(DEST_PCL) |-> (!READY) [*7] ##1 READY;
  endproperty
  a_skip_time: assert property (p_skip_time) else $error("skip penalty wrong");
  property p_tbl_last;
    ISSUE && READY && OPCODE == mbx_pkg::OP_TABLE_READ_LAST
      |=> ROM_ADDR == {mbx_pkg::LAST_PAGE, $past(TABLE_POINTER_LOW)}
      ##3 MEM_WE && MEM_WDATA == $past(ROM_DATA[7:0]);
  endproperty
  a_tbl_last: assert property (p_tbl_last) else $error("last page read wrong");
  property p_wdog;
    ISSUE && READY && OPCODE == mbx_pkg::OP_WDOG_CLEAR && !WDT_TIMEOUT
      |=> WATCHDOG_CLEAR && !TIMEOUT_FLAG && !POWERDOWN_FLAG ##1 !WATCHDOG_CLEAR;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog clear wrong");
  property p_halt;
    ISSUE && READY && OPCODE == mbx_pkg::OP_HALT && !WDT_TIMEOUT
      |=> WATCHDOG_CLEAR && POWERDOWN_FLAG && !TIMEOUT_FLAG ##3 HALTED && !READY;
  endproperty
  a_halt: assert property (p_halt) else $error("halt entry wrong");
  property p_add_time;
    ISSUE && READY && OPCODE == mbx_pkg::OP_ADD |=> (!READY) [*3] ##1 READY;
  endproperty
  a_add_time: assert property (p_add_time) else $error("add timing wrong");
  property p_add_imm;
    ISSUE && READY && OPCODE == mbx_pkg::OP_ADD_IMM
      |=> {CARRY_FLAG, WORKING_REGISTER} == 9'($past(WORKING_REGISTER)) + 9'($past(IMM));
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");
  property p_add_mem;
    ISSUE && READY && OPCODE == mbx_pkg::OP_ADD_MEM
      |=> MEM_WE && MEM_WDATA == 8'($past(WORKING_REGISTER) + $past(MEM_RDATA));
  endproperty
  a_add_mem: assert property (p_add_mem) else $error("add to memory wrong");
endmodule

bind mbx_exec mbx_exec_monitor i_mbx_exec_monitor (
  .MCLK(MCLK), .RESETN(RESETN), .ISSUE(ISSUE), .OPCODE(OPCODE), .IMM(IMM),
  .BIT_SEL(BIT_SEL), .DEST_PCL(DEST_PCL), .MEM_RDATA(MEM_RDATA),
  .TABLE_POINTER_LOW(TABLE_POINTER_LOW), .ROM_DATA(ROM_DATA), .WDT_TIMEOUT(WDT_TIMEOUT),
  .READY(READY), .SKIP(SKIP), .PC_LOAD(PC_LOAD), .HALTED(HALTED),
  .WATCHDOG_CLEAR(WATCHDOG_CLEAR), .ROM_ADDR(ROM_ADDR), .MEM_WE(MEM_WE),
  .MEM_WDATA(MEM_WDATA), .WORKING_REGISTER(WORKING_REGISTER), .CARRY_FLAG(CARRY_FLAG),
  .TIMEOUT_FLAG(TIMEOUT_FLAG), .POWERDOWN_FLAG(POWERDOWN_FLAG)
);

`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench: a table of operations, then table reads, halt,
// watchdog and a second reset by hand.
// Assumes the package, the unit and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  typedef struct {
    mbx_pkg::mbx_op_t op;
    logic [7:0] v;
    logic [2:0] bs;
    logic       p;
    logic [1:0] n;
    logic       sk;
    logic [7:0] acc;
    logic [3:0] fl;
    logic [7:0] wd;
    logic [3:0] ctl;
  } mbx_row_t;

  logic             MCLK, RESETN, ISSUE, DEST_PCL, TBL_HIGH_OPT, WDT_TIMEOUT, WAKE;
  mbx_pkg::mbx_op_t OPCODE;
  logic [7:0]       IMM, MEM_RDATA, TABLE_POINTER_LOW, MEM_WDATA, WORKING_REGISTER;
  logic [2:0]       BIT_SEL, TABLE_POINTER_HIGH, PC_PAGE;
  logic [13:0]      ROM_DATA;
  logic             READY, SKIP, PC_LOAD, STACK_PUSH, STACK_POP, INT_RETURN, HALTED;
  logic             WATCHDOG_CLEAR, ROM_RD, MEM_WE, CARRY_FLAG, HALF_CARRY_FLAG;
  logic             ZERO_FLAG, OVERFLOW_FLAG, TIMEOUT_FLAG, POWERDOWN_FLAG, sk_s, wd_s, rd_s;
  logic [10:0]      ROM_ADDR, ad_s;
  logic [5:0]       TABLE_HIGH_LATCH;
  logic [3:0]       flags, ctl_s;
  int               cyc, failures = 0, tests_run = 0, ticks = 0;
  mbx_row_t rows [27] = '{
    '{mbx_pkg::OP_ADD_IMM,8'h7f,3'h0,1'b0,2'h1,1'b0,8'h7f,4'h0,8'h00,4'h0},
    '{mbx_pkg::OP_ADD,8'h01,3'h0,1'b0,2'h1,1'b0,8'h80,4'ha,8'h00,4'h0},
    '{mbx_pkg::OP_ADD_IMM,8'h80,3'h0,1'b0,2'h1,1'b0,8'h00,4'hd,8'h00,4'h0},
    '{mbx_pkg::OP_ADD_CARRY,8'h0f,3'h0,1'b0,2'h1,1'b0,8'h10,4'h2,8'h00,4'h0},
    '{mbx_pkg::OP_ADD_CARRY_MEM,8'hff,3'h0,1'b0,2'h1,1'b0,8'h10,4'h1,8'h0f,4'h0},
    '{mbx_pkg::OP_ADD_MEM,8'hf0,3'h0,1'b1,2'h2,1'b0,8'h10,4'h5,8'h00,4'h0},
    '{mbx_pkg::OP_SKIP_ZERO,8'h00,3'h0,1'b0,2'h2,1'b1,8'h10,4'h5,8'h00,4'h0},
    '{mbx_pkg::OP_SKIP_ZERO,8'h01,3'h0,1'b0,2'h1,1'b0,8'h10,4'h5,8'h00,4'h0},
    '{mbx_pkg::OP_SKIP_ZERO_COPY,8'h00,3'h0,1'b0,2'h2,1'b1,8'h00,4'h5,8'h00,4'h0},
    '{mbx_pkg::OP_SKIP_BIT_CLR,8'hf7,3'h3,1'b0,2'h2,1'b1,8'h00,4'h5,8'h00,4'h0},
    '{mbx_pkg::OP_SKIP_BIT_SET,8'h80,3'h7,1'b0,2'h2,1'b1,8'h00,4'h5,8'h00,4'h0},
    '{mbx_pkg::OP_SKIP_BIT_SET,8'h7f,3'h7,1'b0,2'h1,1'b0,8'h00,4'h5,8'h00,4'h0},
    '{mbx_pkg::OP_INC_SKIP,8'hff,3'h0,1'b1,2'h3,1'b1,8'h00,4'h5,8'h00,4'h0},
    '{mbx_pkg::OP_DEC_SKIP,8'h05,3'h0,1'b0,2'h1,1'b0,8'h00,4'h5,8'h04,4'h0},
    '{mbx_pkg::OP_INC_SKIP_W,8'hff,3'h0,1'b1,2'h2,1'b1,8'h00,4'h5,8'h04,4'h0},
    '{mbx_pkg::OP_DEC_SKIP_W,8'h03,3'h0,1'b0,2'h1,1'b0,8'h02,4'h5,8'h04,4'h0},
    '{mbx_pkg::OP_SWAP_W,8'ha5,3'h0,1'b0,2'h1,1'b0,8'h5a,4'h5,8'h04,4'h0},
    '{mbx_pkg::OP_SWAP,8'h3c,3'h0,1'b1,2'h2,1'b0,8'h5a,4'h5,8'hc3,4'h0},
    '{mbx_pkg::OP_CLEAR,8'h77,3'h0,1'b0,2'h1,1'b0,8'h5a,4'h5,8'h00,4'h0},
    '{mbx_pkg::OP_SET,8'h77,3'h0,1'b0,2'h1,1'b0,8'h5a,4'h5,8'hff,4'h0},
    '{mbx_pkg::OP_NOP,8'h00,3'h0,1'b1,2'h1,1'b0,8'h5a,4'h5,8'hff,4'h0},
    '{mbx_pkg::OP_JUMP,8'h00,3'h0,1'b0,2'h2,1'b0,8'h5a,4'h5,8'hff,4'h8},
    '{mbx_pkg::OP_CALL,8'h00,3'h0,1'b0,2'h2,1'b0,8'h5a,4'h5,8'hff,4'hc},
    '{mbx_pkg::OP_RETURN,8'h00,3'h0,1'b0,2'h2,1'b0,8'h5a,4'h5,8'hff,4'ha},
    '{mbx_pkg::OP_INT_RETURN,8'h00,3'h0,1'b0,2'h2,1'b0,8'h5a,4'h5,8'hff,4'hb},
    '{mbx_pkg::OP_RETURN_IMM,8'h9e,3'h0,1'b0,2'h2,1'b0,8'h9e,4'h5,8'hff,4'ha},
    '{mbx_pkg::OP_ADD_IMM,8'h62,3'h0,1'b0,2'h1,1'b0,8'h00,4'h7,8'hff,4'h0}};

  assign flags = {OVERFLOW_FLAG, ZERO_FLAG, HALF_CARRY_FLAG, CARRY_FLAG};

  mbx_exec i_mbx_exec (
    .MCLK(MCLK), .RESETN(RESETN), .ISSUE(ISSUE), .OPCODE(OPCODE), .IMM(IMM),
    .BIT_SEL(BIT_SEL), .DEST_PCL(DEST_PCL), .TBL_HIGH_OPT(TBL_HIGH_OPT),
    .MEM_RDATA(MEM_RDATA), .TABLE_POINTER_LOW(TABLE_POINTER_LOW),
    .TABLE_POINTER_HIGH(TABLE_POINTER_HIGH), .PC_PAGE(PC_PAGE), .ROM_DATA(ROM_DATA),
    .WDT_TIMEOUT(WDT_TIMEOUT), .WAKE(WAKE), .READY(READY), .SKIP(SKIP), .PC_LOAD(PC_LOAD),
    .STACK_PUSH(STACK_PUSH), .STACK_POP(STACK_POP), .INT_RETURN(INT_RETURN),
    .HALTED(HALTED), .WATCHDOG_CLEAR(WATCHDOG_CLEAR), .ROM_RD(ROM_RD), .ROM_ADDR(ROM_ADDR),
    .MEM_WE(MEM_WE), .MEM_WDATA(MEM_WDATA), .TABLE_HIGH_LATCH(TABLE_HIGH_LATCH),
    .WORKING_REGISTER(WORKING_REGISTER), .CARRY_FLAG(CARRY_FLAG),
    .HALF_CARRY_FLAG(HALF_CARRY_FLAG), .ZERO_FLAG(ZERO_FLAG),
    .OVERFLOW_FLAG(OVERFLOW_FLAG), .TIMEOUT_FLAG(TIMEOUT_FLAG),
    .POWERDOWN_FLAG(POWERDOWN_FLAG)
  );

  always #4 MCLK = ~MCLK;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Issues one operation, records the pulses and counts clocks until ready.
  task automatic go(input mbx_pkg::mbx_op_t op, input logic [7:0] v, input logic [2:0] bs,
                    input logic p);
    @(posedge MCLK);
    OPCODE <= op;
    MEM_RDATA <= v;
    IMM <= v;
    BIT_SEL <= bs;
    DEST_PCL <= p;
    ISSUE <= 1'b1;
    @(posedge MCLK);
    ISSUE <= 1'b0;
    #1;
    sk_s = SKIP;
    wd_s = WATCHDOG_CLEAR;
    rd_s = ROM_RD;
    ad_s = ROM_ADDR;
    ctl_s = {PC_LOAD, STACK_PUSH, STACK_POP, INT_RETURN};
    cyc = 1;
    while (READY !== 1'b1 && cyc < 40) begin
      @(posedge MCLK);
      #1;
      cyc++;
    end
  endtask

  task automatic tbl(input mbx_pkg::mbx_op_t op, input logic opt, input logic p,
                     input logic [10:0] addr, input int clks);
    @(posedge MCLK);
    TBL_HIGH_OPT <= opt;
    go(op, 8'h00, 3'h0, p);
    chk("table address", 16'(ad_s), 16'(addr));
    chk("table fetch", 16'(rd_s), 16'h0001);
    chk("table low", 16'(MEM_WDATA), 16'h005b);
    chk("table high", 16'(TABLE_HIGH_LATCH), 16'h002a);
    chk("table cycles", 16'(cyc), 16'(clks));
    $display("Table read test done");
  endtask

  task automatic pulse_timeout();
    @(posedge MCLK);
    WDT_TIMEOUT <= 1'b1;
    @(posedge MCLK);
    WDT_TIMEOUT <= 1'b0;
  endtask

  always @(posedge MCLK) begin
    ticks++;
    if (ticks == 3000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    MCLK = 1'b0;
    RESETN = 1'b0;
    ISSUE = 1'b0;
    OPCODE = mbx_pkg::OP_NOP;
    {IMM, MEM_RDATA, BIT_SEL, DEST_PCL, TBL_HIGH_OPT, WDT_TIMEOUT, WAKE} = '0;
    TABLE_POINTER_LOW = 8'h4c;
    TABLE_POINTER_HIGH = 3'h5;
    PC_PAGE = 3'h2;
    ROM_DATA = 14'h2a5b;
    repeat (8) @(posedge MCLK);
    chk("ready in reset", 16'(READY), 16'h0001);
    chk("acc in reset", 16'(WORKING_REGISTER), 16'h0000);
    RESETN <= 1'b1;
    $display("Reset test done");
    for (int i = 0; i < 27; i++) begin
      go(rows[i].op, rows[i].v, rows[i].bs, rows[i].p);
      chk("cycles", 16'(cyc), 16'({rows[i].n, 2'b00}));
      chk("skip", 16'(sk_s), 16'(rows[i].sk));
      chk("acc", 16'(WORKING_REGISTER), 16'(rows[i].acc));
      chk("flags", 16'(flags), 16'(rows[i].fl));
      chk("write data", 16'(MEM_WDATA), 16'(rows[i].wd));
      chk("control", 16'(ctl_s), 16'(rows[i].ctl));
      $display("Row %0d done", i);
    end
    tbl(mbx_pkg::OP_TABLE_READ, 1'b1, 1'b0, 11'h54c, 8);
    tbl(mbx_pkg::OP_TABLE_READ, 1'b0, 1'b1, 11'h24c, 12);
    tbl(mbx_pkg::OP_TABLE_READ_LAST, 1'b0, 1'b0, 11'h74c, 8);
    go(mbx_pkg::OP_HALT, 8'h00, 3'h0, 1'b0);
    chk("halted", 16'({HALTED, READY, POWERDOWN_FLAG, TIMEOUT_FLAG, wd_s}), 16'h0015);
    @(posedge MCLK);
    WAKE <= 1'b1;
    @(posedge MCLK);
    WAKE <= 1'b0;
    #1;
    chk("woken", 16'({HALTED, READY}), 16'h0001);
    $display("Halt test done");
    pulse_timeout();
    go(mbx_pkg::OP_WDOG_PRE1, 8'h00, 3'h0, 1'b0);
    chk("one preclear", 16'({TIMEOUT_FLAG, POWERDOWN_FLAG, wd_s}), 16'h0006);
    go(mbx_pkg::OP_WDOG_PRE2, 8'h00, 3'h0, 1'b0);
    chk("both preclears", 16'({TIMEOUT_FLAG, POWERDOWN_FLAG, wd_s}), 16'h0001);
    pulse_timeout();
    go(mbx_pkg::OP_WDOG_CLEAR, 8'h00, 3'h0, 1'b0);
    chk("watchdog clear", 16'({TIMEOUT_FLAG, POWERDOWN_FLAG, wd_s, cyc[3:0]}), 16'h0014);
    $display("Watchdog test done");
    @(posedge MCLK);
    RESETN <= 1'b0;
    #1;
    chk("second reset", 16'({READY, flags, POWERDOWN_FLAG}), 16'h0020);
    repeat (2) @(posedge MCLK);
    RESETN <= 1'b1;
    go(mbx_pkg::OP_ADD_IMM, 8'h11, 3'h0, 1'b0);
    chk("after reset", 16'({cyc[3:0], WORKING_REGISTER}), 16'h0411);
    $display("Second reset test done");
    summarize();
  end
endmodule

`default_nettype wire
